// ===== hw/repeater_defines.vh
`ifndef REPEATER_DEFINES_VH
`define REPEATER_DEFINES_VH

// ==========================================================
// word index map (byte address = 4 * index)
`define LANE_COUNT 8
`define LANE_REGS 8
`define IDX_LANE_LAST 7'h3F
`define IDX_SLAVE_ADDR 7'h40
`define IDX_POINTER 7'h41
`define IDX_DATA_PORT 7'h42
`define IDX_STATUS 7'h43

// ==========================================================
// per-lane register slots
`define LREG_SIGDET 3'h0
`define LREG_BOOST 3'h1
`define LREG_EQCTL 3'h2
`define LREG_DCGAIN 3'h3
`define LREG_FIR_PP 3'h4
`define LREG_FIR_MAIN 3'h5
`define LREG_MODE 3'h6
`define LREG_STATUS 3'h7

// writable bits per slot
`define MASK_SIGDET 8'h03
`define MASK_BOOST 8'h3F
`define MASK_EQCTL 8'h0F
`define MASK_DCGAIN 8'h07
`define MASK_FIR_PP 8'hFF
`define MASK_FIR_MAIN 8'h0F
`define MASK_MODE 8'h01
`define LANE_RESET_VAL 8'h00

// field positions
`define SD_MODE_LSB 0
`define EQ1_BYPASS_BIT 0
`define BW_LSB 1
`define WB_GAIN_BIT 3
`define LIMIT_MODE_BIT 0

// signal-detect modes
`define SD_AUTO 2'b00
`define SD_FORCE_ON 2'b01
`define SD_FORCE_OFF 2'b10

// strap levels, ascending code order 0, R, F, 1
`define STRAP_LVL_0 2'b00
`define STRAP_LVL_R 2'b01
`define STRAP_LVL_F 2'b10
`define STRAP_LVL_1 2'b11
`define SLAVE_ADDR_BASE 7'h18

// ==========================================================
// timing
`define CLK_MHZ 100
`define POR_STRETCH_MS 60
`define POR_STRETCH_CYC (`POR_STRETCH_MS * 1000 * `CLK_MHZ)
`define EE_LOAD_BYTES 64

`endif

// ===== hw/repeater_lane_config_control.v
`timescale 1ns/100ps
`include "repeater_defines.vh"

module repeater_lane_config_control #(
    parameter POR_CYCLES = `POR_STRETCH_CYC,
    parameter LOAD_BYTES = `EE_LOAD_BYTES
) (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [8:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output wire [31:0] WB_DAT_O,
    output wire WB_ACK_O,
    input wire [1:0] ADDR_STRAP_HI,
    input wire [1:0] ADDR_STRAP_LO,
    input wire MGMT_ROLE_STRAP,
    input wire LOAD_TRIGGER_N,
    output wire LOAD_DONE_N_O,
    output wire LOAD_DONE_N_OE,
    input wire MGMT_BUS_CLOCK,
    input wire EE_BYTE_VALID,
    input wire [7:0] EE_BYTE,
    input wire [7:0] SIGNAL_DETECT,
    output wire [7:0] LANE_PATH_EN,
    output wire [23:0] EQ1_BOOST,
    output wire [23:0] EQ2_BOOST,
    output wire [7:0] EQ1_BYPASS,
    output wire [15:0] EQ_BW,
    output wire [7:0] WB_GAIN_HI,
    output wire [23:0] DC_GAIN,
    output wire [7:0] LIMIT_MODE,
    output wire [31:0] FIR_PRE,
    output wire [31:0] FIR_POST,
    output wire [31:0] FIR_MAIN
);

    // ==========================================================
    // functions
    function [7:0] slot_mask;
        input [2:0] slot;
        begin
            case (slot)
                `LREG_SIGDET: slot_mask = `MASK_SIGDET;
                `LREG_BOOST: slot_mask = `MASK_BOOST;
                `LREG_EQCTL: slot_mask = `MASK_EQCTL;
                `LREG_DCGAIN: slot_mask = `MASK_DCGAIN;
                `LREG_FIR_PP: slot_mask = `MASK_FIR_PP;
                `LREG_FIR_MAIN: slot_mask = `MASK_FIR_MAIN;
                `LREG_MODE: slot_mask = `MASK_MODE;
                default: slot_mask = 8'h00;
            endcase
        end
    endfunction

    // strap codes already ascend 0, R, F, 1
    function [6:0] strap_addr;
        input [1:0] hi;
        input [1:0] lo;
        begin
            strap_addr = `SLAVE_ADDR_BASE + {3'b000, hi, lo};
        end
    endfunction

    // ==========================================================
    // pin synchronisers
    reg [1:0] hi_s1_q, hi_s2_q, lo_s1_q, lo_s2_q;
    reg role_s1_q, role_s2_q, trig_s1_q, trig_s2_q, sclk_s1_q, sclk_s2_q, sclk_prev_q;
    reg [7:0] sd_s1_q, sd_s2_q;

    always @(posedge CLK) begin
        if (RST) begin
            hi_s1_q <= 2'b00;
            hi_s2_q <= 2'b00;
            lo_s1_q <= 2'b00;
            lo_s2_q <= 2'b00;
            role_s1_q <= 1'b0;
            role_s2_q <= 1'b0;
            trig_s1_q <= 1'b1;
            trig_s2_q <= 1'b1;
            sclk_s1_q <= 1'b1;
            sclk_s2_q <= 1'b1;
            sclk_prev_q <= 1'b1;
            sd_s1_q <= 8'h00;
            sd_s2_q <= 8'h00;
        end else if (CE) begin
            hi_s1_q <= ADDR_STRAP_HI;
            hi_s2_q <= hi_s1_q;
            lo_s1_q <= ADDR_STRAP_LO;
            lo_s2_q <= lo_s1_q;
            role_s1_q <= MGMT_ROLE_STRAP;
            role_s2_q <= role_s1_q;
            trig_s1_q <= LOAD_TRIGGER_N;
            trig_s2_q <= trig_s1_q;
            sclk_s1_q <= MGMT_BUS_CLOCK;
            sclk_s2_q <= sclk_s1_q;
            sclk_prev_q <= sclk_s2_q;
            sd_s1_q <= SIGNAL_DETECT;
            sd_s2_q <= sd_s1_q;
        end
    end

    wire slave_mode = role_s2_q;
    wire trig_low = ~trig_s2_q;
    wire lane_clear = slave_mode & trig_low;
    wire sclk_rise = sclk_s2_q & ~sclk_prev_q;

    // ==========================================================
    // power-on reset stretch and strap latch
    reg [22:0] por_cnt_q;
    reg por_done_q;
    reg [6:0] slave_addr_q;
    reg [7:0] activity_q;

    always @(posedge CLK) begin
        if (RST) begin
            por_cnt_q <= 23'h00_0000;
            por_done_q <= 1'b0;
            slave_addr_q <= `SLAVE_ADDR_BASE;
            activity_q <= 8'h00;
        end else if (CE) begin
            if (!por_done_q) begin
                if (por_cnt_q >= POR_CYCLES[22:0] - 23'h00_0001) begin
                    por_done_q <= 1'b1;
                    slave_addr_q <= strap_addr(hi_s2_q, lo_s2_q);
                end else begin
                    por_cnt_q <= por_cnt_q + 23'h00_0001;
                end
            end
            if (sclk_rise) begin
                activity_q <= activity_q + 8'h01;
            end
        end
    end

    // ==========================================================
    // eeprom self-load in master mode
    reg load_busy_q, load_done_q;
    reg [6:0] load_cnt_q;
    wire load_start = por_done_q & ~slave_mode & trig_low & ~load_busy_q & ~load_done_q;
    wire load_write = load_busy_q & EE_BYTE_VALID;

    always @(posedge CLK) begin
        if (RST) begin
            load_busy_q <= 1'b0;
            load_done_q <= 1'b0;
            load_cnt_q <= 7'h00;
        end else if (CE) begin
            if (load_start) begin
                load_busy_q <= 1'b1;
                load_cnt_q <= 7'h00;
            end else if (load_write) begin
                if (load_cnt_q == LOAD_BYTES[6:0] - 7'h01) begin
                    load_busy_q <= 1'b0;
                    load_done_q <= 1'b1;
                end
                load_cnt_q <= load_cnt_q + 7'h01;
            end
        end
    end

    // slave mode only pulls low while trigger held low; master pulls low once loaded
    assign LOAD_DONE_N_O = 1'b0;
    assign LOAD_DONE_N_OE = slave_mode ? trig_low : load_done_q;

    // ==========================================================
    // wishbone slave, one wait state
    reg ack_q;
    reg [31:0] dat_q;
    reg [5:0] ptr_q;
    reg [7:0] lane_q [0:63];
    wire req = WB_CYC_I & WB_STB_I & ~ack_q;
    wire [6:0] idx = WB_ADR_I[8:2];
    wire bus_wr = req & WB_WE_I & WB_SEL_I[0] & por_done_q;
    wire [7:0] wbyte = WB_DAT_I[7:0];
    wire lane_hit = ~idx[6];
    wire port_wr = bus_wr & (idx == `IDX_DATA_PORT) & ~load_busy_q;
    wire ptr_wr = bus_wr & (idx == `IDX_POINTER) & ~load_busy_q;
    wire direct_wr = bus_wr & lane_hit;
    wire ind_wr = port_wr | load_write;
    wire [7:0] ind_byte = load_write ? EE_BYTE : wbyte;

    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (!por_done_q) begin
            rd_byte = 8'h00;
        end else if (lane_hit && idx[2:0] == `LREG_STATUS) begin
            rd_byte = {7'h00, sd_s2_q[idx[5:3]]};
        end else if (lane_hit) begin
            rd_byte = lane_q[idx[5:0]];
        end else if (idx == `IDX_SLAVE_ADDR) begin
            rd_byte = {1'b0, slave_addr_q};
        end else if (idx == `IDX_POINTER) begin
            rd_byte = {2'b00, ptr_q};
        end else if (idx == `IDX_DATA_PORT) begin
            rd_byte = lane_q[ptr_q];
        end else if (idx == `IDX_STATUS) begin
            rd_byte = {4'h0, load_done_q, load_busy_q, slave_mode, por_done_q};
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            ptr_q <= 6'h00;
        end else if (CE) begin
            ack_q <= req;
            if (req) begin
                dat_q <= (!WB_WE_I && idx == `IDX_STATUS && por_done_q) ?
                    {16'h0000, activity_q, rd_byte} : {24'h00_0000, rd_byte};
            end
            if (load_start) begin
                ptr_q <= 6'h00;
            end else if (ind_wr) begin
                ptr_q <= ptr_q + 6'h01;
            end else if (ptr_wr) begin
                ptr_q <= wbyte[5:0];
            end
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    // ==========================================================
    // lane register file
    integer i;
    always @(posedge CLK) begin
        if (RST || (CE && lane_clear)) begin
            for (i = 0; i < 64; i = i + 1) begin
                lane_q[i] <= `LANE_RESET_VAL;
            end
        end else if (CE) begin
            // one byte per cycle; eeprom load beats a direct host write
            if (ind_wr) begin
                lane_q[ptr_q] <= ind_byte & slot_mask(ptr_q[2:0]);
            end else if (direct_wr) begin
                lane_q[idx[5:0]] <= wbyte & slot_mask(idx[2:0]);
            end
        end
    end

    // ==========================================================
    // per-lane field outputs
    genvar g;
    generate
        for (g = 0; g < `LANE_COUNT; g = g + 1) begin : lane
            wire [7:0] sdr = lane_q[g * `LANE_REGS + `LREG_SIGDET];
            wire [7:0] bst = lane_q[g * `LANE_REGS + `LREG_BOOST];
            wire [7:0] eqc = lane_q[g * `LANE_REGS + `LREG_EQCTL];
            wire [7:0] dcg = lane_q[g * `LANE_REGS + `LREG_DCGAIN];
            wire [7:0] fpp = lane_q[g * `LANE_REGS + `LREG_FIR_PP];
            wire [7:0] fmn = lane_q[g * `LANE_REGS + `LREG_FIR_MAIN];
            wire [7:0] mde = lane_q[g * `LANE_REGS + `LREG_MODE];
            wire [1:0] sdm = sdr[`SD_MODE_LSB +: 2];
            // force-off wins so a lane can be parked regardless of input energy
            assign LANE_PATH_EN[g] = (sdm == `SD_FORCE_OFF) ? 1'b0 :
                (sdm == `SD_FORCE_ON) ? 1'b1 : sd_s2_q[g];
            assign EQ1_BOOST[3 * g +: 3] = bst[2:0];
            assign EQ2_BOOST[3 * g +: 3] = bst[5:3];
            assign EQ1_BYPASS[g] = eqc[`EQ1_BYPASS_BIT];
            assign EQ_BW[2 * g +: 2] = eqc[`BW_LSB +: 2];
            assign WB_GAIN_HI[g] = eqc[`WB_GAIN_BIT];
            assign DC_GAIN[3 * g +: 3] = dcg[2:0];
            assign LIMIT_MODE[g] = mde[`LIMIT_MODE_BIT];
            // tap signs are fixed in the analog path, only magnitudes here
            assign FIR_PRE[4 * g +: 4] = fpp[3:0];
            assign FIR_POST[4 * g +: 4] = fpp[7:4];
            assign FIR_MAIN[4 * g +: 4] = fmn[3:0];
        end
    endgenerate

endmodule

// ===== verification/repeater_properties.sv
`timescale 1ns/100ps
module repeater_properties (
    input wire CLK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire MGMT_ROLE_STRAP,
    input wire LOAD_TRIGGER_N,
    input wire LOAD_DONE_N_O,
    input wire LOAD_DONE_N_OE,
    input wire [7:0] SIGNAL_DETECT,
    input wire [7:0] LANE_PATH_EN,
    input wire [23:0] DC_GAIN,
    input wire [7:0] LIMIT_MODE,
    input wire [23:0] EQ1_BOOST
);
    // ============================================
    // six cycles so the pin has crossed its synchroniser
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence trig_held;
        (MGMT_ROLE_STRAP && !LOAD_TRIGGER_N) [*6];
    endsequence
    sequence trig_free;
        (MGMT_ROLE_STRAP && LOAD_TRIGGER_N) [*6];
    endsequence
    AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_DAT_HOLD: assert property ($changed(WB_DAT_O) |-> WB_ACK_O)
        else $error("read data moved without ack");
    AST_PIN_LOW: assert property (LOAD_DONE_N_OE |-> !LOAD_DONE_N_O)
        else $error("done pin driven high");
    AST_OE_DRIVE: assert property (trig_held |-> LOAD_DONE_N_OE)
        else $error("done pin not driven while trigger low");
    AST_OE_FREE: assert property (trig_free |-> !LOAD_DONE_N_OE)
        else $error("done pin driven while trigger high");
    AST_TRIG_CLEAR: assert property (trig_held |-> !(DC_GAIN || LIMIT_MODE || EQ1_BOOST))
        else $error("lane fields kept under trigger reset");
    AST_PATH_AUTO: assert property (trig_held |-> LANE_PATH_EN == $past(SIGNAL_DETECT, 2))
        else $error("datapath enable not following detect");
endmodule

// ===== verification/repeater_far_side.sv
`timescale 1ns/100ps
module repeater_far_side (
    input wire CLK,
    input wire done_n_o,
    input wire done_n_oe,
    output logic mgmt_clk,
    output logic ee_valid,
    output logic [7:0] ee_byte,
    output wire done_n
);
    logic frame;
    // ============================================
    // pulled-up done line, bus clock idles high between frames
    assign done_n = done_n_oe ? done_n_o : 1'h1;
    initial begin
        mgmt_clk = 1'h1;
        frame = 1'h0;
        ee_valid = 1'h0;
        ee_byte = 8'h00;
    end
    always #80 if (frame || !mgmt_clk) mgmt_clk = ~mgmt_clk;
    task automatic burst(input int n);
        frame = 1'h1;
        repeat (n) @(posedge mgmt_clk);
        frame = 1'h0;
    endtask
    task automatic ee_send(input logic [7:0] b);
        @(posedge CLK);
        ee_valid <= 1'h1;
        ee_byte <= b;
        @(posedge CLK);
        ee_valid <= 1'h0;
        ee_byte <= ~b;
    endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam int POR = 20;
    logic clk, rst, cyc, stb, we, role, trig_n;
    logic [8:0] adr;
    logic [7:0] dat, sd;
    logic [3:0] sel;
    logic [1:0] hi, lo;
    logic [31:0] rd;
    logic [7:0] mask [1:6] = '{8'h3F, 8'h0F, 8'h07, 8'hFF, 8'h0F, 8'h01};
    logic [7:0] ld [4] = '{8'h02, 8'h2D, 8'h0B, 8'h05};
    wire ack, oe, dno, mclk, eev, done_n;
    wire [7:0] eeb, path, byp, gh, lim;
    wire [31:0] rdat, pre, post, mainf;
    wire [23:0] eq1, eq2, dcg;
    wire [15:0] bw;
    int errors, checks_done;
    repeater_lane_config_control #(.POR_CYCLES(POR), .LOAD_BYTES(4)) u_dut (
        .CLK(clk), .RST(rst), .CE(1'h1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I({24'h00_0000, dat}), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .ADDR_STRAP_HI(hi), .ADDR_STRAP_LO(lo), .MGMT_ROLE_STRAP(role),
        .LOAD_TRIGGER_N(trig_n), .LOAD_DONE_N_O(dno), .LOAD_DONE_N_OE(oe),
        .MGMT_BUS_CLOCK(mclk), .EE_BYTE_VALID(eev), .EE_BYTE(eeb), .SIGNAL_DETECT(sd),
        .LANE_PATH_EN(path), .EQ1_BOOST(eq1), .EQ2_BOOST(eq2), .EQ1_BYPASS(byp), .EQ_BW(bw),
        .WB_GAIN_HI(gh), .DC_GAIN(dcg), .LIMIT_MODE(lim), .FIR_PRE(pre), .FIR_POST(post),
        .FIR_MAIN(mainf));
    repeater_far_side u_far (.CLK(clk), .done_n_o(dno), .done_n_oe(oe), .mgmt_clk(mclk),
        .ee_valid(eev), .ee_byte(eeb), .done_n(done_n));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // ============================================
    // bus access and compare helpers
    task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 40);
        if (ack !== 1'h1) begin
            errors++;
            $display("[FAIL] %0t bus request not acknowledged", $time);
        end
        rd = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] val(input int n, input int k);
        return 8'h3C ^ 8'(n * 37 + k * 11);
    endfunction
    function automatic logic [31:0] flds(input int n);
        return {6'h00, eq1[3*n+:3], eq2[3*n+:3], byp[n], bw[2*n+:2], gh[n], dcg[3*n+:3],
                pre[4*n+:4], post[4*n+:4], mainf[4*n+:4], lim[n]};
    endfunction
    function automatic logic [31:0] want(input int n);
        logic [7:0] a, b, c, d, e, f;
        a = val(n, 1);
        b = val(n, 2);
        c = val(n, 3);
        d = val(n, 4);
        e = val(n, 5);
        f = val(n, 6);
        return {6'h00, a[2:0], a[5:3], b[0], b[2:1], b[3], c[2:0], d[3:0], d[7:4], e[3:0], f[0]};
    endfunction
    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
    // ============================================
    // straps read back through the slave address register
    initial begin
        {errors, checks_done} = '0;
        {rst, role, trig_n, cyc, stb, we} = 6'h38;
        {adr, dat, sel, hi, lo, sd} = {21'h00_0000, 4'h9, 8'hA5};
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        wb(1'h1, 9'h00C, 8'h07, 4'h1);
        wb(1'h0, 9'h10C, 8'h00, 4'h1);
        chk(rd, 32'h0000_0000);
        repeat (POR + 8) @(posedge clk);
        wb(1'h0, 9'h00C, 8'h00, 4'h1);
        chk(rd, 32'h0000_0000);
        wb(1'h0, 9'h10C, 8'h00, 4'h1);
        chk(rd, 32'h0000_0003);
        wb(1'h0, 9'h100, 8'h00, 4'h1);
        chk(rd, 32'h0000_0021);
        {hi, lo} <= 4'hF;
        for (int n = 0; n < 8; n++) begin
            for (int k = 1; k < 7; k++) begin
                wb(1'h1, 9'(n * 32 + k * 4), val(n, k), 4'h1);
            end
        end
        wb(1'h1, 9'h00C, 8'h00, 4'hE);
        for (int n = 0; n < 8; n++) begin
            for (int k = 1; k < 7; k++) begin
                wb(1'h0, 9'(n * 32 + k * 4), 8'h00, 4'h1);
                chk(rd, {24'h00_0000, val(n, k) & mask[k]});
            end
            chk(flds(n), want(n));
        end
        wb(1'h1, 9'h018, 8'h01, 4'h1);
        chk({31'h0000_0000, lim[0]}, 32'h0000_0001);
        wb(1'h1, 9'h018, 8'h00, 4'h1);
        chk({31'h0000_0000, lim[0]}, 32'h0000_0000);
        wb(1'h1, 9'h01C, 8'hFF, 4'h1);
        wb(1'h0, 9'h01C, 8'h00, 4'h1);
        chk(rd, {31'h0000_0000, sd[0]});
        for (int m = 0; m < 8; m++) begin
            sd[0] <= m[0];
            wb(1'h1, 9'h000, 8'(m >> 1), 4'h1);
            repeat (3) @(posedge clk);
            chk({30'h0000_0000, path[1:0]},
                {30'h0, sd[1], m[2:1] == 1 || (m[2:1] != 2 && m[0])});
        end
        trig_n <= 1'h0;
        repeat (8) @(posedge clk);
        chk({31'h0000_0000, done_n}, 32'h0000_0000);
        chk(pre | post | mainf | {eq1, byp} | {eq2, lim} | {dcg, gh} | {16'h0000, bw}, 32'h0);
        trig_n <= 1'h1;
        repeat (6) @(posedge clk);
        chk({31'h0000_0000, done_n}, 32'h0000_0001);
        wb(1'h0, 9'h100, 8'h00, 4'h1);
        chk(rd, 32'h0000_0021);
        {rst, role} <= 2'h2;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        repeat (POR + 8) @(posedge clk);
        wb(1'h0, 9'h100, 8'h00, 4'h1);
        chk(rd, 32'h0000_0027);
        trig_n <= 1'h0;
        u_far.burst(9);
        foreach (ld[i]) u_far.ee_send(ld[i]);
        trig_n <= 1'h1;
        repeat (6) @(posedge clk);
        chk(flds(0), {6'h00, 3'h5, 3'h5, 1'h1, 2'h1, 1'h1, 3'h5, 13'h0000});
        chk({30'h0000_0000, path[0], done_n}, 32'h0000_0000);
        wb(1'h0, 9'h10C, 8'h00, 4'h1);
        chk(rd, 32'h0000_0909);
        wb(1'h1, 9'h104, 8'h13, 4'h1);
        wb(1'h1, 9'h108, 8'h06, 4'h1);
        wb(1'h1, 9'h108, 8'hA7, 4'h1);
        wb(1'h0, 9'h104, 8'h00, 4'h1);
        chk(rd, 32'h0000_0015);
        wb(1'h0, 9'h04C, 8'h00, 4'h1);
        chk(rd, 32'h0000_0006);
        wb(1'h1, 9'h104, 8'h14, 4'h1);
        wb(1'h0, 9'h108, 8'h00, 4'h1);
        chk(rd, 32'h0000_00A7);
        give_verdict();
    end
endmodule
bind repeater_lane_config_control repeater_properties u_props (
    .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .WB_DAT_O(WB_DAT_O), .MGMT_ROLE_STRAP(MGMT_ROLE_STRAP), .LOAD_TRIGGER_N(LOAD_TRIGGER_N),
    .LOAD_DONE_N_O(LOAD_DONE_N_O), .LOAD_DONE_N_OE(LOAD_DONE_N_OE),
    .SIGNAL_DETECT(SIGNAL_DETECT), .LANE_PATH_EN(LANE_PATH_EN), .DC_GAIN(DC_GAIN),
    .LIMIT_MODE(LIMIT_MODE), .EQ1_BOOST(EQ1_BOOST));
